// File: verilog/pwmsel_pkg.sv
// Package with register map and constants of the pulse pin select block
package pwmsel_pkg;
  localparam int unsigned ADDR_W = 12;
  // Register index; the byte address is four times it on the word-wide bus
  localparam logic [ADDR_W-1:0] PULSE_PIN_SELECT_IDX = 12'h00D;
  localparam logic [ADDR_W-1:0] PULSE_PIN_SELECT_OFS = {PULSE_PIN_SELECT_IDX[ADDR_W-3:0], 2'b00};
  localparam logic [7:0] PULSE_PIN_SELECT_RST = 8'h7F;
  localparam logic [31:0] READ_ZERO = 32'h0000_0000;
  localparam int unsigned RES_BIT = 7;
  localparam int unsigned PIN_LSB = 1;
  localparam int unsigned PIN_CNT = 6;
  localparam logic [7:0] DEFINED_MASK = 8'hFE;
endpackage

// File: verilog/pwmsel_reg.sv
// Storage cell for the pulse pin select byte
`timescale 1ns/100ps
module pwmsel_reg (
  input wire logic i_mclk,
  input wire logic i_nrst,
  input wire logic i_we,
  input wire logic [7:0] i_wdata,
  output logic [7:0] o_value
);
  logic [7:0] next_value;

  always_comb
  begin
    next_value = o_value;
    if (i_we)
    begin
      next_value = i_wdata;
    end
  end

  always_ff @(posedge i_mclk)
  begin
    if (!i_nrst)
    begin
      o_value <= pwmsel_pkg::PULSE_PIN_SELECT_RST;
    end
    else
    begin
      o_value <= next_value;
    end
  end
endmodule // pwmsel_reg

// File: verilog/pwmsel_top.sv
// APB slave holding the pulse pin select register and its pin selects
`timescale 1ns/100ps
module pwmsel_top (
  input wire logic i_mclk,
  input wire logic i_nrst,
  input wire logic i_psel,
  input wire logic i_penable,
  input wire logic i_pwrite,
  input wire logic [11:0] i_paddr,
  input wire logic [31:0] i_pwdata,
  input wire logic [3:0] i_pstrb,
  output logic o_pready,
  output logic o_pslverr,
  output logic [31:0] o_prdata,
  output logic o_pulse_channel_six_14bit,
  output logic [5:0] o_port_select
);
  logic [7:0] reg_value;
  logic hit;
  logic wr_en;
  logic next_pready;
  logic next_pslverr;
  logic [31:0] next_prdata;
  logic [7:0] next_wdata;

  // Single-cycle access phase: ready is registered from the setup cycle and is high in the access cycle
  assign hit = (i_paddr == pwmsel_pkg::PULSE_PIN_SELECT_OFS);
  // Commit only at the access edge where ready is high
  assign wr_en = i_psel && i_penable && o_pready && i_pwrite && hit && i_pstrb[0];
  assign next_wdata = i_pwdata[7:0] & pwmsel_pkg::DEFINED_MASK;

  pwmsel_reg u_reg (
    .i_mclk(i_mclk),
    .i_nrst(i_nrst),
    .i_we(wr_en),
    .i_wdata(next_wdata),
    .o_value(reg_value)
  );

  always_comb
  begin
    next_pready = 1'b0;
    next_pslverr = 1'b0;
    next_prdata = pwmsel_pkg::READ_ZERO;
    if (i_psel && !i_penable)
    begin
      next_pready = 1'b1;
      next_pslverr = !hit;
      if (hit && !i_pwrite)
      begin
        next_prdata = {24'h00_0000, reg_value};
      end
    end
  end

  always_ff @(posedge i_mclk)
  begin
    if (!i_nrst)
    begin
      o_pready <= 1'b0;
      o_pslverr <= 1'b0;
      o_prdata <= pwmsel_pkg::READ_ZERO;
    end
    else
    begin
      o_pready <= next_pready;
      o_pslverr <= next_pslverr;
      o_prdata <= next_prdata;
    end
  end

  // Selects follow the register one edge later so outputs stay registered
  always_ff @(posedge i_mclk)
  begin
    if (!i_nrst)
    begin
      o_pulse_channel_six_14bit <= pwmsel_pkg::PULSE_PIN_SELECT_RST[pwmsel_pkg::RES_BIT];
      o_port_select <= pwmsel_pkg::PULSE_PIN_SELECT_RST[pwmsel_pkg::PIN_LSB +: pwmsel_pkg::PIN_CNT];
    end
    else
    begin
      o_pulse_channel_six_14bit <= reg_value[pwmsel_pkg::RES_BIT];
      // Bit n high hands pin to port5 bit n, low to the pulse channel
      o_port_select <= reg_value[pwmsel_pkg::PIN_LSB +: pwmsel_pkg::PIN_CNT];
    end
  end

  // Setup then access, the two steps of every bus transfer
  sequence apb_setup_s;
    i_psel && !i_penable;
  endsequence

  sequence apb_access_s;
    i_psel && i_penable && o_pready;
  endsequence

  sequence mapped_write_s;
    apb_setup_s ##0 (i_pwrite && hit && i_pstrb[0]);
  endsequence

  res_follow_a:
    assert property (@(posedge i_mclk) disable iff (!i_nrst)
      o_pulse_channel_six_14bit == $past(reg_value[pwmsel_pkg::RES_BIT]))
    else $error("resolution select does not follow register");

  pin11_follow_a:
    assert property (@(posedge i_mclk) disable iff (!i_nrst)
      o_port_select[5] == $past(reg_value[6]))
    else $error("pin select 6 wrong");

  pin6_follow_a:
    assert property (@(posedge i_mclk) disable iff (!i_nrst)
      o_port_select[4] == $past(reg_value[5]))
    else $error("pin select 5 wrong");

  pin5_follow_a:
    assert property (@(posedge i_mclk) disable iff (!i_nrst)
      o_port_select[3] == $past(reg_value[4]))
    else $error("pin select 4 wrong");

  pin4_follow_a:
    assert property (@(posedge i_mclk) disable iff (!i_nrst)
      o_port_select[2] == $past(reg_value[3]))
    else $error("pin select 3 wrong");

  pin3_follow_a:
    assert property (@(posedge i_mclk) disable iff (!i_nrst)
      o_port_select[1] == $past(reg_value[2]))
    else $error("pin select 2 wrong");

  pin2_follow_a:
    assert property (@(posedge i_mclk) disable iff (!i_nrst)
      o_port_select[0] == $past(reg_value[1]))
    else $error("pin select 1 wrong");

  reset_value_a:
    assert property (@(posedge i_mclk)
      $rose(i_nrst) |-> reg_value == pwmsel_pkg::PULSE_PIN_SELECT_RST)
    else $error("reset value wrong");

  // Outputs must show defaults one edge into reset, whatever came before
  reset_outputs_a:
    assert property (@(posedge i_mclk)
      !i_nrst |=> (!o_pready && !o_pslverr && o_prdata == pwmsel_pkg::READ_ZERO
        && o_pulse_channel_six_14bit == pwmsel_pkg::PULSE_PIN_SELECT_RST[pwmsel_pkg::RES_BIT]
        && o_port_select == pwmsel_pkg::PULSE_PIN_SELECT_RST[7:1]))
    else $error("outputs not at reset defaults");

  write_back_a:
    assert property (@(posedge i_mclk) disable iff (!i_nrst)
      wr_en |=> reg_value == ($past(i_pwdata[7:0]) & pwmsel_pkg::DEFINED_MASK))
    else $error("write lost");

  read_back_a:
    assert property (@(posedge i_mclk) disable iff (!i_nrst)
      (apb_setup_s ##0 (!i_pwrite && hit)) |=> o_prdata == {24'h00_0000, $past(reg_value)})
    else $error("read data wrong");

  setup_answer_a:
    assert property (@(posedge i_mclk) disable iff (!i_nrst)
      apb_setup_s |=> o_pready)
    else $error("no ready after setup");

  ready_pulse_a:
    assert property (@(posedge i_mclk) disable iff (!i_nrst)
      o_pready |=> !o_pready)
    else $error("ready held too long");

  err_with_ready_a:
    assert property (@(posedge i_mclk) disable iff (!i_nrst)
      o_pslverr |-> o_pready)
    else $error("error without ready");

  err_unmapped_a:
    assert property (@(posedge i_mclk) disable iff (!i_nrst)
      (apb_setup_s ##0 !hit) |=> o_pslverr)
    else $error("unmapped access not flagged");

  no_err_mapped_a:
    assert property (@(posedge i_mclk) disable iff (!i_nrst)
      (apb_setup_s ##0 hit) |=> !o_pslverr)
    else $error("mapped access flagged");

  unmapped_zero_a:
    assert property (@(posedge i_mclk) disable iff (!i_nrst)
      (apb_setup_s ##0 (!hit && !i_pwrite)) |=> o_prdata == pwmsel_pkg::READ_ZERO)
    else $error("unmapped read not zero");

  idle_rdata_a:
    assert property (@(posedge i_mclk) disable iff (!i_nrst)
      !o_pready |-> o_prdata == pwmsel_pkg::READ_ZERO)
    else $error("read data outside answer");

  write_commit_a:
    assert property (@(posedge i_mclk) disable iff (!i_nrst)
      (mapped_write_s ##1 apb_access_s)
        |=> reg_value == ($past(i_pwdata[7:0]) & pwmsel_pkg::DEFINED_MASK))
    else $error("write transfer not committed");

  // Lane 0 off means software did not intend to touch the byte
  strobe_hold_a:
    assert property (@(posedge i_mclk) disable iff (!i_nrst)
      (apb_setup_s ##0 (i_pwrite && hit && !i_pstrb[0]) ##1 apb_access_s)
        |=> $stable(reg_value))
    else $error("write without lane 0 changed register");

  unmapped_hold_a:
    assert property (@(posedge i_mclk) disable iff (!i_nrst)
      (apb_setup_s ##0 (i_pwrite && !hit) ##1 apb_access_s) |=> $stable(reg_value))
    else $error("unmapped write changed register");

  no_write_idle_a:
    assert property (@(posedge i_mclk) disable iff (!i_nrst)
      !wr_en |=> $stable(reg_value))
    else $error("register changed without write");

  bit_zero_a:
    assert property (@(posedge i_mclk) disable iff (!i_nrst)
      wr_en |=> !reg_value[0])
    else $error("undefined bit stored");
endmodule // pwmsel_top

// File: bench/test_pwm_pin_select_register.sv
// Self-checking testbench for the pulse pin select register
`timescale 1ns/100ps
module test_pwm_pin_select_register;
  logic i_mclk = 1'b0, i_nrst = 1'b0, i_psel = 1'b0, i_penable = 1'b0, i_pwrite = 1'b0;
  logic [11:0] i_paddr = 12'h000;
  logic [31:0] i_pwdata = 32'h0000_0000;
  logic [3:0] i_pstrb = 4'hF;
  logic o_pready, o_pslverr, o_pulse_channel_six_14bit, err;
  logic [31:0] o_prdata, rd;
  logic [5:0] o_port_select;
  int miscompares = 0, samples_checked = 0;
  localparam logic [11:0] REG_A = pwmsel_pkg::PULSE_PIN_SELECT_OFS;
  pwmsel_top dut_u (.i_mclk(i_mclk), .i_nrst(i_nrst), .i_psel(i_psel), .i_penable(i_penable),
    .i_pwrite(i_pwrite), .i_paddr(i_paddr), .i_pwdata(i_pwdata), .i_pstrb(i_pstrb),
    .o_pready(o_pready), .o_pslverr(o_pslverr), .o_prdata(o_prdata),
    .o_pulse_channel_six_14bit(o_pulse_channel_six_14bit), .o_port_select(o_port_select));
  initial forever #4 i_mclk = ~i_mclk;
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    samples_checked++;
    if (g !== e)
    begin
      miscompares++;
      $display("ERROR %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d, input logic [3:0] s);
    int n;
    n = 0;
    i_psel <= 1'b1;
    i_pwrite <= w;
    i_paddr <= a;
    i_pwdata <= d;
    i_pstrb <= s;
    @(posedge i_mclk);
    i_penable <= 1'b1;
    @(negedge i_mclk);
    while (o_pready !== 1'b1 && n < 16)
    begin
      @(negedge i_mclk);
      n++;
    end
    if (n >= 16) chk("pready", 32'h0000_0001, {31'h0000_0000, o_pready});
    rd = o_prdata;
    err = o_pslverr;
    @(posedge i_mclk);
    i_psel <= 1'b0;
    i_penable <= 1'b0;
    @(posedge i_mclk);
  endtask
  // Settle two edges: selects lag the register by one
  task automatic t_look(input logic [7:0] e);
    repeat (2) @(posedge i_mclk);
    chk("res14", {31'h0000_0000, e[7]}, {31'h0000_0000, o_pulse_channel_six_14bit});
    chk("pinsel", {26'h000_0000, e[6:1]}, {26'h000_0000, o_port_select});
    apb(1'b0, REG_A, 32'h0000_0000, 4'hF);
    chk("rdata", {24'h00_0000, e}, rd);
    chk("slverr", 32'h0000_0000, {31'h0000_0000, err});
  endtask
  task automatic t_reset(input int n);
    i_nrst <= 1'b0;
    repeat (n) @(posedge i_mclk);
    i_nrst <= 1'b1;
    @(posedge i_mclk);
    t_look(8'h7F);
  endtask
  task automatic t_cfg(input logic [7:0] v, input logic [3:0] s, input logic [7:0] e);
    apb(1'b1, REG_A, {24'hFF_FF00, v}, s);
    t_look(e);
  endtask
  task automatic t_unmapped();
    apb(1'b1, REG_A + 12'h004, 32'h0000_00FF, 4'hF);
    chk("wr_err", 32'h0000_0001, {31'h0000_0000, err});
    apb(1'b0, REG_A - 12'h004, 32'h0000_0000, 4'hF);
    chk("rd_err", 32'h0000_0001, {31'h0000_0000, err});
    chk("rd_zero", 32'h0000_0000, rd);
  endtask
  task automatic conclude();
    if (miscompares == 0 && samples_checked > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  initial
  begin
    #40000;
    miscompares++;
    conclude();
  end
  initial
  begin
    t_reset(20);
    t_cfg(8'hFF, 4'hF, 8'hFE);
    t_cfg(8'h80, 4'hF, 8'h80);
    t_cfg(8'h2A, 4'hF, 8'h2A);
    t_cfg(8'h55, 4'hE, 8'h2A);
    t_cfg(8'h54, 4'hF, 8'h54);
    t_unmapped();
    t_look(8'h54);
    t_reset(2);
    conclude();
  end
endmodule // test_pwm_pin_select_register
